// ---- rtl/usr_pkg.sv ----
// Purpose: constants for the suspend/resume and transmit-mode controller
// Assumes: 8-bit register port, one clock
// Notes: register offsets follow the write/set/clear triplet layout
package usr_pkg;
    // register addresses: write, set, clear
    localparam logic [5:0] FUNC_WR = 6'h04;
    localparam logic [5:0] FUNC_SET = 6'h05;
    localparam logic [5:0] FUNC_CLR = 6'h06;
    localparam logic [5:0] INTF_WR = 6'h07;
    localparam logic [5:0] INTF_SET = 6'h08;
    localparam logic [5:0] INTF_CLR = 6'h09;
    localparam logic [5:0] OTG_WR = 6'h0a;
    localparam logic [5:0] OTG_SET = 6'h0b;
    localparam logic [5:0] OTG_CLR = 6'h0c;
    // reset values
    localparam logic [7:0] FUNC_RST = 8'h41;
    localparam logic [7:0] INTF_RST = 8'h00;
    localparam logic [7:0] OTG_RST = 8'h06;
    // function control fields
    localparam int SPEED_LSB = 0;
    localparam int TERM_BIT = 2;
    localparam int OPERATING_MODE_FIELD_LSB = 3;
    localparam int SUSP_BIT = 6;
    // interface control fields
    localparam int SIX_PIN_BIT = 0;
    localparam int THREE_PIN_BIT = 1;
    // otg control fields
    localparam int PLUS_PD_BIT = 1;
    localparam int MINUS_PD_BIT = 2;
    // operating modes
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_NO_STUFF_NRZI = 2'h2;
    localparam logic [1:0] OPM_NO_SYNC_EOP = 2'h3;
    // line states and special bytes
    localparam logic [1:0] LS_K = 2'h1;
    localparam logic [7:0] BYTE_NO_STUFF_EOP = 8'hfe;
    localparam logic [7:0] BYTE_NO_EOP = 8'h00;
    localparam logic [7:0] PID_SOF = 8'ha5;
    // receive command byte layout
    localparam int RXCMD_LS_LSB = 0;
    localparam int RXCMD_VB_LSB = 2;
    localparam int RXCMD_SESSION_END_CMP_BIT = 4;

    typedef enum logic [1:0] {
        usr_eop_normal,
        usr_eop_no_stuff,
        usr_eop_long
    } usr_eop_e;

    typedef enum logic [1:0] {
        usr_tx_idle,
        usr_tx_first,
        usr_tx_body
    } usr_tx_e;
endpackage

// ---- rtl/usr_rxcmd.sv ----
// Purpose: builds receive commands on line state or comparator change
// Assumes: comparator and line-state inputs already synchronous
// Notes: held back while the block itself drives resume K
`timescale 1ns/1ps
module usr_rxcmd (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [1:0] bus_line_state,
    input wire logic host_vbus_valid_cmp,
    input wire logic session_valid_cmp,
    input wire logic session_end_cmp,
    input wire logic hold_off,
    output logic rxcmd_valid,
    output logic [7:0] rxcmd_byte
);
    // ------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------
    logic [4:0] snap_reg;
    logic [4:0] now_w;
    logic changed_w;
    logic [1:0] vbus_code_w;

    // vbus code: 0 below session valid, 1 session valid, 3 host vbus valid
    assign vbus_code_w = host_vbus_valid_cmp ? 2'h3 : (session_valid_cmp ? 2'h1 : 2'h0);
    assign now_w = {session_end_cmp, vbus_code_w, bus_line_state};
    // a change seen during hold-off stays pending until hold-off ends
    assign changed_w = (now_w != snap_reg) && !hold_off;

    // ------------------------------------------------------------
    // command register
    // ------------------------------------------------------------
    // snapshot only moves when a command goes out, so nothing is lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            snap_reg <= 5'h00;
            rxcmd_valid <= 1'b0;
            rxcmd_byte <= 8'h00;
        end else begin
            rxcmd_valid <= changed_w;
            if (changed_w) begin
                snap_reg <= now_w;
                rxcmd_byte <= {3'h0, now_w};
            end
        end
    end
endmodule

// ---- rtl/usr_ctrl.sv ----
// Purpose: transceiver-side suspend, resume and transmit-mode control
// Assumes: link side signals synchronous to sys_clk; registers via plain port
// Notes: eop decisions are one-cycle pulses to the serialiser
`timescale 1ns/1ps
module usr_ctrl (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_cmd,
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_stp,
    input wire logic [1:0] bus_line_state,
    input wire logic host_vbus_valid_cmp,
    input wire logic session_valid_cmp,
    input wire logic session_end_cmp,
    output logic rxcmd_valid,
    output logic [7:0] rxcmd_byte,
    output logic [1:0] transceiver_speed_select,
    output logic termination_select,
    output logic [1:0] operating_mode_field,
    output logic suspend_control_n,
    output logic plus_line_pulldown_en,
    output logic minus_line_pulldown_en,
    output logic six_pin_serial_sel,
    output logic three_pin_serial_sel,
    output logic auto_sync_en,
    output logic stuff_nrzi_en,
    output logic eop_pulse,
    output logic [1:0] eop_kind,
    output logic resume_eop_pulse,
    output logic resume_k_drive
);
    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    logic [7:0] func_reg;
    logic [7:0] intf_reg;
    logic [7:0] otg_reg;
    logic [7:0] func_next;
    logic [7:0] intf_next;
    logic [7:0] otg_next;
    logic [7:0] rdata_w;
    logic wake_w;

    // write replaces, set ors, clear masks off
    function automatic logic [7:0] usr_upd(input logic [7:0] cur, input logic [5:0] base,
                                           input logic [5:0] addr, input logic [7:0] d,
                                           input logic wr);
        logic [7:0] r;
        r = cur;
        if (wr && addr == base) begin
            r = d;
        end else if (wr && addr == base + 6'h01) begin
            r = cur | d;
        end else if (wr && addr == base + 6'h02) begin
            r = cur & ~d;
        end
        return r;
    endfunction

    // stp while suspended wakes the transceiver; hardware set wins over clear
    assign wake_w = tx_stp && !func_reg[usr_pkg::SUSP_BIT];
    assign func_next = usr_upd(func_reg, usr_pkg::FUNC_WR, reg_addr, reg_wdata, reg_wr)
                     | ({7'h00, wake_w} << usr_pkg::SUSP_BIT);
    assign intf_next = usr_upd(intf_reg, usr_pkg::INTF_WR, reg_addr, reg_wdata, reg_wr);
    assign otg_next = usr_upd(otg_reg, usr_pkg::OTG_WR, reg_addr, reg_wdata, reg_wr);

    // each register reads back at all three of its addresses
    assign rdata_w = (reg_addr >= usr_pkg::FUNC_WR && reg_addr <= usr_pkg::FUNC_CLR) ? func_reg :
                     (reg_addr >= usr_pkg::INTF_WR && reg_addr <= usr_pkg::INTF_CLR) ? intf_reg :
                     (reg_addr >= usr_pkg::OTG_WR && reg_addr <= usr_pkg::OTG_CLR) ? otg_reg : 8'h00;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    // read data is forced to zero outside the read cycle so a stale value
    // can never be mistaken for an answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            func_reg <= usr_pkg::FUNC_RST;
            intf_reg <= usr_pkg::INTF_RST;
            otg_reg <= usr_pkg::OTG_RST;
            reg_rdata <= 8'h00;
        end else begin
            func_reg <= func_next;
            intf_reg <= intf_next;
            otg_reg <= otg_next;
            reg_rdata <= reg_rd ? rdata_w : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // field outputs
    // ------------------------------------------------------------
    logic both_pd_w;
    logic [1:0] opm_w;

    // fields are wired straight from the registers; a write shows on the next cycle
    assign opm_w = func_reg[usr_pkg::OPERATING_MODE_FIELD_LSB +: 2];
    assign transceiver_speed_select = func_reg[usr_pkg::SPEED_LSB +: 2];
    assign termination_select = func_reg[usr_pkg::TERM_BIT];
    assign operating_mode_field = opm_w;
    assign suspend_control_n = func_reg[usr_pkg::SUSP_BIT];
    assign plus_line_pulldown_en = otg_reg[usr_pkg::PLUS_PD_BIT];
    assign minus_line_pulldown_en = otg_reg[usr_pkg::MINUS_PD_BIT];
    assign six_pin_serial_sel = intf_reg[usr_pkg::SIX_PIN_BIT];
    assign three_pin_serial_sel = intf_reg[usr_pkg::THREE_PIN_BIT];
    // both pulldowns mark the host side
    assign both_pd_w = plus_line_pulldown_en && minus_line_pulldown_en;
    // sync and eop generation off only in mode 11b; stuffing stays on
    assign auto_sync_en = (opm_w != usr_pkg::OPM_NO_SYNC_EOP);
    assign stuff_nrzi_en = (opm_w != usr_pkg::OPM_NO_STUFF_NRZI);

    // ------------------------------------------------------------
    // transmit tracking
    // ------------------------------------------------------------
    usr_pkg::usr_tx_e tx_reg;
    usr_pkg::usr_tx_e tx_next;
    logic sof_reg;
    logic sof_next;
    logic first_sof_w;
    logic no_sync_w;
    logic stp_in_pkt_w;
    logic resume_mode_w;
    logic [1:0] kind_w;
    logic eop_go_w;
    logic resume_end_w;

    // mode decode shared by the eop and resume paths
    assign no_sync_w = (opm_w == usr_pkg::OPM_NO_SYNC_EOP);
    assign resume_mode_w = (opm_w == usr_pkg::OPM_NO_STUFF_NRZI);
    assign first_sof_w = (tx_reg == usr_pkg::usr_tx_first) && tx_byte_valid
                       && (tx_byte == usr_pkg::PID_SOF);
    assign stp_in_pkt_w = tx_stp && (tx_reg != usr_pkg::usr_tx_idle);

    // a long sof eop outranks the byte-coded choices
    assign kind_w = (no_sync_w && (sof_reg || first_sof_w)) ? usr_pkg::usr_eop_long :
                    (no_sync_w && tx_byte == usr_pkg::BYTE_NO_STUFF_EOP) ? usr_pkg::usr_eop_no_stuff :
                    usr_pkg::usr_eop_normal;
    // in mode 11b a 00h byte with stp suppresses the eop unless the packet is an sof
    assign eop_go_w = stp_in_pkt_w && !resume_mode_w
                    && !(no_sync_w && tx_byte == usr_pkg::BYTE_NO_EOP && !sof_reg);
    // stop of resume drive: eop only on the host side
    assign resume_end_w = stp_in_pkt_w && resume_mode_w && both_pd_w;

    // packet tracker: the command opens a packet, the first byte after it is
    // the pid, stop closes it; a stop before any byte still ends the packet,
    // and the sof flag is only latched from that first byte
    always_comb begin
        tx_next = tx_reg;
        sof_next = sof_reg;
        case (tx_reg)
            usr_pkg::usr_tx_idle: begin
                sof_next = 1'b0;
                if (tx_cmd) begin
                    tx_next = usr_pkg::usr_tx_first;
                end
            end
            usr_pkg::usr_tx_first: begin
                if (tx_stp) begin
                    tx_next = usr_pkg::usr_tx_idle;
                end else if (tx_byte_valid) begin
                    sof_next = first_sof_w;
                    tx_next = usr_pkg::usr_tx_body;
                end
            end
            usr_pkg::usr_tx_body: begin
                if (tx_stp) begin
                    tx_next = usr_pkg::usr_tx_idle;
                end
            end
            default: begin
                tx_next = usr_pkg::usr_tx_idle;
            end
        endcase
    end

    // eop pulses are registered so the serialiser sees clean strobes
    // trade-off: one cycle of latency bought glitch-free pulses
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_reg <= usr_pkg::usr_tx_idle;
            sof_reg <= 1'b0;
            eop_pulse <= 1'b0;
            eop_kind <= usr_pkg::usr_eop_normal;
            resume_eop_pulse <= 1'b0;
            resume_k_drive <= 1'b0;
        end else begin
            tx_reg <= tx_next;
            sof_reg <= sof_next;
            eop_pulse <= eop_go_w;
            eop_kind <= eop_go_w ? kind_w : usr_pkg::usr_eop_normal;
            resume_eop_pulse <= resume_end_w;
            // resume K runs from the command in mode 10b until stp
            if (tx_cmd && resume_mode_w) begin
                resume_k_drive <= 1'b1;
            end else if (tx_stp) begin
                resume_k_drive <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // receive commands
    // ------------------------------------------------------------
    // no receive commands after the first cycle of resume K driven by this end
    usr_rxcmd u_rxcmd (
        .sys_clk(sys_clk),
        .srst(srst),
        .bus_line_state(bus_line_state),
        .host_vbus_valid_cmp(host_vbus_valid_cmp),
        .session_valid_cmp(session_valid_cmp),
        .session_end_cmp(session_end_cmp),
        .hold_off(resume_k_drive),
        .rxcmd_valid(rxcmd_valid),
        .rxcmd_byte(rxcmd_byte)
    );
endmodule

// ---- testbench/usr_ctrl_checker.sv ----
// Purpose: port-level checks on the transceiver mode controller
// Assumes: one clock, srst synchronous active high
// Notes: checks read the controller's ports, inputs as well as outputs
`timescale 1ns/1ps
module usr_ctrl_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_cmd,
    input wire logic [7:0] tx_byte,
    input wire logic tx_stp,
    input wire logic [1:0] bus_line_state,
    input wire logic rxcmd_valid,
    input wire logic [7:0] rxcmd_byte,
    input wire logic [1:0] operating_mode_field,
    input wire logic suspend_control_n,
    input wire logic plus_line_pulldown_en,
    input wire logic minus_line_pulldown_en,
    input wire logic auto_sync_en,
    input wire logic stuff_nrzi_en,
    input wire logic eop_pulse,
    input wire logic [1:0] eop_kind,
    input wire logic resume_eop_pulse,
    input wire logic resume_k_drive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // stop seen in the raw-packet mode, the eop decision follows one cycle later
    sequence s_raw_stp;
        tx_stp && operating_mode_field == 2'h3;
    endsequence
    a_sync_mode_off: assert property (auto_sync_en == (operating_mode_field != 2'h3)) else $error("auto sync wrong");
    a_stuff_kept_raw: assert property (operating_mode_field == 2'h3 |-> stuff_nrzi_en) else $error("stuffing off");
    a_nostuff_eop_byte: assert property (eop_pulse && eop_kind == 2'h1 |-> $past(tx_stp) && $past(tx_byte) == 8'hfe)
        else $error("no-stuff eop without fe");
    a_zero_no_eop: assert property (s_raw_stp ##0 tx_byte == 8'h00 |=> !eop_pulse || eop_kind == 2'h2)
        else $error("eop after 00 stop");
    a_long_eop_mode: assert property (eop_pulse && eop_kind == 2'h2 |-> $past(operating_mode_field) == 2'h3)
        else $error("long eop outside raw mode");
    a_resume_eop_host: assert property (resume_eop_pulse |-> $past(tx_stp) && $past(plus_line_pulldown_en)
        && $past(minus_line_pulldown_en)) else $error("resume eop without host pulldowns");
    a_rx_hold_drive: assert property (resume_k_drive && $past(resume_k_drive) |-> !rxcmd_valid)
        else $error("rxcmd during resume drive");
    a_wake_on_stp: assert property (tx_stp && !suspend_control_n |=> suspend_control_n)
        else $error("stop did not wake");
    a_rx_line_state: assert property (rxcmd_valid |-> rxcmd_byte[1:0] == $past(bus_line_state) && rxcmd_byte[7:5] == 3'h0)
        else $error("rxcmd line state wrong");
    a_resume_mode_drive: assert property (tx_cmd && operating_mode_field == 2'h2 && !resume_k_drive |=> resume_k_drive)
        else $error("resume k not driven");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 6'h20 |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule
bind usr_ctrl usr_ctrl_checker u_chk (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_cmd(tx_cmd), .tx_byte(tx_byte), .tx_stp(tx_stp), .bus_line_state(bus_line_state),
    .rxcmd_valid(rxcmd_valid), .rxcmd_byte(rxcmd_byte), .operating_mode_field(operating_mode_field),
    .suspend_control_n(suspend_control_n), .plus_line_pulldown_en(plus_line_pulldown_en),
    .minus_line_pulldown_en(minus_line_pulldown_en), .auto_sync_en(auto_sync_en), .stuff_nrzi_en(stuff_nrzi_en),
    .eop_pulse(eop_pulse), .eop_kind(eop_kind), .resume_eop_pulse(resume_eop_pulse), .resume_k_drive(resume_k_drive));

// ---- testbench/usr_link_model.sv ----
// Purpose: link controller model driving the transmit side
// Assumes: requests change just after a rising edge
// Notes: data byte shows the inverse of the last value once released
`timescale 1ns/1ps
module usr_link_model (
    input wire logic sys_clk,
    output logic tx_cmd,
    output logic tx_byte_valid,
    output logic [7:0] tx_byte,
    output logic tx_stp
);
    initial begin
        tx_cmd = 1'b0;
        tx_byte_valid = 1'b0;
        tx_byte = 8'h00;
        tx_stp = 1'b0;
    end
    // stop with a data byte, then release the byte
    task automatic fin(input logic [7:0] b);
        tx_stp <= 1'b1;
        tx_byte <= b;
        @(posedge sys_clk);
        tx_stp <= 1'b0;
        tx_byte <= ~b;
    endtask
    // every raw packet opens with a plain transmit command, pid in the first byte
    task automatic pkt(input logic [7:0] f, input logic [7:0] l);
        @(posedge sys_clk);
        tx_cmd <= 1'b1;
        @(posedge sys_clk);
        tx_cmd <= 1'b0;
        tx_byte_valid <= 1'b1;
        tx_byte <= f;
        @(posedge sys_clk);
        tx_byte_valid <= 1'b0;
        fin(l);
    endtask
    // resume drive is only started by the bench after it sets mode 10b
    task automatic res_start();
        @(posedge sys_clk);
        tx_cmd <= 1'b1;
        @(posedge sys_clk);
        tx_cmd <= 1'b0;
    endtask
    // stop ends resume drive and wakes a suspended transceiver
    task automatic stop();
        @(posedge sys_clk);
        fin(8'h00);
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the mode controller
// Assumes: 200 MHz clock, register port answers in one cycle
// Notes: each scenario judges its own results before returning
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] bus_line_state = 2'h0;
    logic vb = 1'b0;
    logic sv = 1'b0;
    logic se = 1'b0;
    logic tx_cmd, tx_byte_valid, tx_stp, rxcmd_valid, six, three, auto_sync_en, stuff_nrzi_en;
    logic eop_pulse, resume_eop_pulse, resume_k_drive, term, susp_n, pd_p, pd_m;
    logic [7:0] tx_byte, reg_rdata, rxcmd_byte;
    logic [1:0] speed, opm, eop_kind;
    int miscompares = 0;
    int checked = 0;
    int n;
    usr_link_model u_link (.sys_clk(sys_clk), .tx_cmd(tx_cmd), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
        .tx_stp(tx_stp));
    usr_ctrl uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_cmd(tx_cmd), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
        .tx_stp(tx_stp), .bus_line_state(bus_line_state), .host_vbus_valid_cmp(vb), .session_valid_cmp(sv),
        .session_end_cmp(se), .rxcmd_valid(rxcmd_valid), .rxcmd_byte(rxcmd_byte), .transceiver_speed_select(speed),
        .termination_select(term), .operating_mode_field(opm), .suspend_control_n(susp_n),
        .plus_line_pulldown_en(pd_p), .minus_line_pulldown_en(pd_m), .six_pin_serial_sel(six),
        .three_pin_serial_sel(three), .auto_sync_en(auto_sync_en), .stuff_nrzi_en(stuff_nrzi_en),
        .eop_pulse(eop_pulse), .eop_kind(eop_kind), .resume_eop_pulse(resume_eop_pulse),
        .resume_k_drive(resume_k_drive));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    // always look past the next edge, so a pulse from the previous change is not taken again
    task automatic wait_rx(input logic [7:0] e);
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            #1;
            if (rxcmd_valid === 1'b1) break;
        end
        `CHK("rxcmd_valid", 1'b1, rxcmd_valid)
        `CHK("rxcmd_byte", e, rxcmd_byte)
    endtask
    // reset values, set/clear access, serial mode bits and an unmapped place
    task automatic t_regs();
        rd(usr_pkg::FUNC_WR, 8'h41);
        rd(usr_pkg::OTG_CLR, 8'h06);
        `CHK("pulldowns", 2'h3, {pd_p, pd_m})
        wr(usr_pkg::FUNC_SET, 8'h04);
        `CHK("termination_select", 1'b1, term)
        `CHK("transceiver_speed_select", 2'h1, speed)
        wr(usr_pkg::FUNC_CLR, 8'h40);
        `CHK("suspend_control_n", 1'b0, susp_n)
        rd(usr_pkg::FUNC_SET, 8'h05);
        wr(usr_pkg::INTF_WR, 8'h03);
        `CHK("serial_sel", 2'h3, {six, three})
        wr(6'h20, 8'hff);
        rd(6'h20, 8'h00);
        @(posedge sys_clk);
        bus_line_state <= 2'h2;
        u_link.stop();
        #1;
        `CHK("suspend_control_n", 1'b1, susp_n)
        @(posedge sys_clk);
        bus_line_state <= 2'h0;
        $display("test t_regs done");
    endtask
    // raw packet mode: every stop coding
    task automatic t_nosync();
        logic [7:0] f[4] = '{8'ha5, 8'hc3, 8'hc3, 8'hc3};
        logic [7:0] l[4] = '{8'h00, 8'hfe, 8'h00, 8'h12};
        logic p[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic [1:0] k[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
        wr(usr_pkg::FUNC_WR, 8'h58);
        `CHK("auto_sync_en", 1'b0, auto_sync_en)
        `CHK("stuff_nrzi_en", 1'b1, stuff_nrzi_en)
        for (int i = 0; i < 4; i++) begin
            u_link.pkt(f[i], l[i]);
            #1;
            `CHK("eop_pulse", p[i], eop_pulse)
            if (p[i]) `CHK("eop_kind", k[i], eop_kind)
        end
        $display("test t_nosync done");
    endtask
    // comparator changes, then resume drive as host and as peripheral
    task automatic t_resume();
        @(posedge sys_clk);
        se <= 1'b1;
        wait_rx(8'h10);
        @(posedge sys_clk);
        vb <= 1'b1;
        sv <= 1'b1;
        wait_rx(8'h1c);
        wr(usr_pkg::FUNC_WR, 8'h50);
        `CHK("stuff_nrzi_en", 1'b0, stuff_nrzi_en)
        `CHK("transceiver_speed_select", 2'h0, speed)
        `CHK("termination_select", 1'b0, term)
        u_link.res_start();
        #1;
        `CHK("resume_k_drive", 1'b1, resume_k_drive)
        @(posedge sys_clk);
        bus_line_state <= 2'h1;
        n = 0;
        repeat (6) begin
            @(posedge sys_clk);
            #1;
            if (rxcmd_valid === 1'b1) n++;
        end
        `CHK("rxcmd_count", 0, n)
        u_link.stop();
        #1;
        `CHK("resume_eop_pulse", 1'b1, resume_eop_pulse)
        `CHK("eop_pulse", 1'b0, eop_pulse)
        wait_rx(8'h1d);
        wr(usr_pkg::OTG_CLR, 8'h06);
        u_link.res_start();
        u_link.stop();
        #1;
        `CHK("resume_eop_pulse", 1'b0, resume_eop_pulse)
        wr(usr_pkg::FUNC_WR, 8'h40);
        `CHK("operating_mode_field", 2'h0, opm)
        `CHK("stuff_nrzi_en", 1'b1, stuff_nrzi_en)
        `CHK("transceiver_speed_select", 2'h0, speed)
        `CHK("termination_select", 1'b0, term)
        $display("test t_resume done");
    endtask
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        t_regs();
        t_nosync();
        t_resume();
        end_sim();
    end
endmodule
